// >>> design/lvc_cfg.svh
// register indices, field positions, reset values and sizes of the video crop and colour block
`ifndef LVC_CFG_SVH
`define LVC_CFG_SVH

`define LVC_IDX_W         3
`define LVC_IDX_CTRL      3'h0
`define LVC_IDX_CROP_X    3'h1
`define LVC_IDX_CROP_Y    3'h2
`define LVC_IDX_WIDTH_M1  3'h3
`define LVC_IDX_HEIGHT_M1 3'h4

`define LVC_REG_W         16
`define LVC_CTRL_W        10
`define LVC_CTRL_RST      10'h001
`define LVC_BIT_ENABLE    0
`define LVC_BIT_MIRROR    1
`define LVC_PAD_HI        3
`define LVC_PAD_LO        2
`define LVC_LOW_SEL_HI    5
`define LVC_LOW_SEL_LO    4
`define LVC_MID_SEL_HI    7
`define LVC_MID_SEL_LO    6
`define LVC_HIGH_SEL_HI   9
`define LVC_HIGH_SEL_LO   8

`define LVC_COORD_W       11
`define LVC_SIZE_W        10
`define LVC_CROP_X_RST    11'h000
`define LVC_CROP_Y_RST    11'h000
`define LVC_WIDTH_M1_RST  10'h0ff
`define LVC_HEIGHT_M1_RST 10'h01f

`define LVC_POS_W         12
`define LVC_PIX_W         24
`define LVC_FIFO_W        46
`define LVC_FIFO_D        16
`define LVC_FIFO_AW       4

`endif

// >>> design/lvc_pkg.sv
// types shared by the video crop and colour block
package lvc_pkg;
    // byte phase of the pixel serialiser, high byte leaves first
    typedef enum logic [1:0] {
        LVC_ST_HI  = 2'b00,
        LVC_ST_MID = 2'b01,
        LVC_ST_LO  = 2'b10
    } lvc_byte_st_t;
endpackage

// >>> design/lvc_crop_color.sv
// crop window, mirroring, padding and colour ordering of the video to strip path, with its registers
`timescale 1ns/1ps
`default_nettype none
`include "lvc_cfg.svh"

// small fifo of flip-flops; full and empty are exact
module lvc_fifo #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0]  mem_r [D];   // storage
    logic [AW-1:0] wp_r, wp_nxt; // write pointer
    logic [AW-1:0] rp_r, rp_nxt; // read pointer
    logic [AW:0]   cnt_r, cnt_nxt; // words held
    logic          push, pop;

    // count is one bit wider than the pointers, so the depth must be compared at that width
    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage is written only, never reset; contents are qualified by the count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_fifo_no_overrun: assert property (cnt_r == (AW+1)'(D) |-> !in_ready ##1 cnt_r <= (AW+1)'(D))
        else $error("fifo full yet accepting");
    a_fifo_pop_empty: assert property (cnt_r == '0 |-> !out_valid && in_ready)
        else $error("fifo empty yet offering or refusing");
endmodule // lvc_fifo

// Operation
// R1 - control bit 0 enables; reads valid-video
// R2 - software rewrites current enable when changing fields
// R3 - control bit 1 mirrors image horizontally
// R4 - bits 3-2 skip leading strip pixels
// R5 - bits 5-4 pick low byte colour
// R6 - bits 7-6 pick middle byte colour
// R7 - bits 9-8 pick high byte colour
// R8 - crop origin x, 11 bits, reset 0
// R9 - crop origin y, 11 bits, reset 0
// R10 - crop width is programmed value plus one
// R11 - crop height is programmed value plus one
// R12 - forward window pixels as high, middle, low
module lvc_crop_color
    import lvc_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    // register port
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [`LVC_IDX_W-1:0]   reg_idx,
    input  wire logic [`LVC_REG_W-1:0]   reg_wdata,
    output logic [`LVC_REG_W-1:0]        reg_rdata,
    // input video
    input  wire logic                    vid_locked,
    input  wire logic                    vid_valid,
    output logic                         vid_ready,
    input  wire logic [`LVC_COORD_W-1:0] vid_x,
    input  wire logic [`LVC_COORD_W-1:0] vid_y,
    input  wire logic [`LVC_PIX_W-1:0]   vid_rgb,
    // strip byte stream
    output logic                         strip_valid,
    input  wire logic                    strip_ready,
    output logic [7:0]                   strip_byte,
    output logic [1:0]                   strip_phase,
    output logic [`LVC_POS_W-1:0]        strip_pos,
    output logic [`LVC_SIZE_W-1:0]       strip_line,
    output logic                         ctrl_enable
);
    logic [`LVC_CTRL_W-1:0]  ctrl_r, ctrl_nxt;          // control fields
    logic [`LVC_COORD_W-1:0] crop_x_r, crop_x_nxt;      // window origin x
    logic [`LVC_COORD_W-1:0] crop_y_r, crop_y_nxt;      // window origin y
    logic [`LVC_SIZE_W-1:0]  width_m1_r, width_m1_nxt;  // window width less one
    logic [`LVC_SIZE_W-1:0]  height_m1_r, height_m1_nxt; // window height less one
    logic [`LVC_REG_W-1:0]   rdata_r, rdata_nxt;        // read answer
    lvc_byte_st_t            st_r, st_nxt;              // serialiser phase

    logic [`LVC_COORD_W:0]   dx, dy;       // offset into window, one bit wider to catch borrow
    logic                    in_win;       // pixel inside crop window
    logic [`LVC_POS_W-1:0]   pos_calc;     // strip position of the pixel
    logic                    fifo_in_valid;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic                    fifo_pop;
    logic [`LVC_FIFO_W-1:0]  fifo_in, fifo_out;
    logic [`LVC_PIX_W-1:0]   head_rgb;

    // register writes; reserved bits are dropped
    always_comb begin
        ctrl_nxt      = ctrl_r;
        crop_x_nxt    = crop_x_r;
        crop_y_nxt    = crop_y_r;
        width_m1_nxt  = width_m1_r;
        height_m1_nxt = height_m1_r;
        if (reg_wr) begin
            if (reg_idx == `LVC_IDX_CTRL) begin
                ctrl_nxt = reg_wdata[`LVC_CTRL_W-1:0]; // [R1] [R3] [R4] [R5] [R6] [R7]
            end else if (reg_idx == `LVC_IDX_CROP_X) begin
                crop_x_nxt = reg_wdata[`LVC_COORD_W-1:0]; // [R8]
            end else if (reg_idx == `LVC_IDX_CROP_Y) begin
                crop_y_nxt = reg_wdata[`LVC_COORD_W-1:0]; // [R9]
            end else if (reg_idx == `LVC_IDX_WIDTH_M1) begin
                width_m1_nxt = reg_wdata[`LVC_SIZE_W-1:0]; // [R10]
            end else if (reg_idx == `LVC_IDX_HEIGHT_M1) begin
                height_m1_nxt = reg_wdata[`LVC_SIZE_W-1:0]; // [R11]
            end
        end
    end

    // read mux; bit 0 of control shows the video detector, not the stored enable
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            rdata_nxt = '0;
            if (reg_idx == `LVC_IDX_CTRL) begin
                rdata_nxt = {{(`LVC_REG_W-`LVC_CTRL_W){1'b0}}, ctrl_r[`LVC_CTRL_W-1:1], vid_locked}; // [R1]
            end else if (reg_idx == `LVC_IDX_CROP_X) begin
                rdata_nxt = {{(`LVC_REG_W-`LVC_COORD_W){1'b0}}, crop_x_r};
            end else if (reg_idx == `LVC_IDX_CROP_Y) begin
                rdata_nxt = {{(`LVC_REG_W-`LVC_COORD_W){1'b0}}, crop_y_r};
            end else if (reg_idx == `LVC_IDX_WIDTH_M1) begin
                rdata_nxt = {{(`LVC_REG_W-`LVC_SIZE_W){1'b0}}, width_m1_r};
            end else if (reg_idx == `LVC_IDX_HEIGHT_M1) begin
                rdata_nxt = {{(`LVC_REG_W-`LVC_SIZE_W){1'b0}}, height_m1_r};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_r      <= `LVC_CTRL_RST; // [R1]
            crop_x_r    <= `LVC_CROP_X_RST;
            crop_y_r    <= `LVC_CROP_Y_RST;
            width_m1_r  <= `LVC_WIDTH_M1_RST;
            height_m1_r <= `LVC_HEIGHT_M1_RST;
            rdata_r     <= '0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            crop_x_r    <= crop_x_nxt;
            crop_y_r    <= crop_y_nxt;
            width_m1_r  <= width_m1_nxt;
            height_m1_r <= height_m1_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata   = rdata_r;
    assign ctrl_enable = ctrl_r[`LVC_BIT_ENABLE];

    // window test: the borrow bit of the offset says the pixel lies left of or above the origin
    always_comb begin
        dx     = {1'b0, vid_x} - {1'b0, crop_x_r};
        dy     = {1'b0, vid_y} - {1'b0, crop_y_r};
        in_win = !dx[`LVC_COORD_W] && (dx[`LVC_COORD_W-1:0] <= {1'b0, width_m1_r})   // [R10]
              && !dy[`LVC_COORD_W] && (dy[`LVC_COORD_W-1:0] <= {1'b0, height_m1_r}); // [R11] [R12]
        // mirroring counts from the right edge of the window instead of the left
        if (ctrl_r[`LVC_BIT_MIRROR]) begin
            pos_calc = `LVC_POS_W'(width_m1_r) - `LVC_POS_W'(dx[`LVC_COORD_W-1:0]); // [R3]
        end else begin
            pos_calc = `LVC_POS_W'(dx[`LVC_COORD_W-1:0]);
        end
        pos_calc = pos_calc + `LVC_POS_W'(ctrl_r[`LVC_PAD_HI:`LVC_PAD_LO]); // [R4]
    end

    // pixels are queued only when enabled and inside the window; the rest are consumed and lost
    assign fifo_in_valid = vid_valid && ctrl_r[`LVC_BIT_ENABLE] && in_win; // [R1] [R12]
    assign vid_ready     = fifo_in_ready;
    assign fifo_in       = {dy[`LVC_SIZE_W-1:0], pos_calc, vid_rgb};

    lvc_fifo #(
        .W  (`LVC_FIFO_W),
        .D  (`LVC_FIFO_D),
        .AW (`LVC_FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // colour picker; rgb word holds red high, green middle, blue low
    function automatic logic [7:0] pick(input logic [1:0] sel, input logic [23:0] rgb, input logic [1:0] st);
        logic [1:0] c;
        c = 2'd0;
        case (st)
            2'd0: c = (sel == 2'b01) ? 2'd1 : (sel == 2'b10) ? 2'd0 : 2'd2; // high: r g b r
            2'd1: c = (sel == 2'b01) ? 2'd2 : (sel == 2'b10) ? 2'd0 : 2'd1; // middle: g r b g
            default: c = (sel == 2'b01) ? 2'd1 : (sel == 2'b10) ? 2'd2 : 2'd0; // low: b g r b
        endcase
        case (c)
            2'd2: pick = rgb[23:16];
            2'd1: pick = rgb[15:8];
            default: pick = rgb[7:0];
        endcase
    endfunction

    // byte serialiser: word leaves the fifo only after its low byte is taken
    always_comb begin
        st_nxt = st_r;
        if (fifo_out_valid && strip_ready) begin
            case (st_r)
                LVC_ST_HI:  st_nxt = LVC_ST_MID;
                LVC_ST_MID: st_nxt = LVC_ST_LO;
                default:    st_nxt = LVC_ST_HI;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r <= LVC_ST_HI;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign head_rgb    = fifo_out[`LVC_PIX_W-1:0];
    assign fifo_pop    = fifo_out_valid && strip_ready && (st_r == LVC_ST_LO); // [R12]
    assign strip_valid = fifo_out_valid;
    assign strip_phase = st_r;
    assign strip_pos   = fifo_out[`LVC_PIX_W +: `LVC_POS_W];
    assign strip_line  = fifo_out[`LVC_FIFO_W-1 -: `LVC_SIZE_W];
    always_comb begin
        case (st_r)
            LVC_ST_HI:  strip_byte = pick(ctrl_r[`LVC_HIGH_SEL_HI:`LVC_HIGH_SEL_LO], head_rgb, 2'd0); // [R7]
            LVC_ST_MID: strip_byte = pick(ctrl_r[`LVC_MID_SEL_HI:`LVC_MID_SEL_LO], head_rgb, 2'd1); // [R6]
            default:    strip_byte = pick(ctrl_r[`LVC_LOW_SEL_HI:`LVC_LOW_SEL_LO], head_rgb, 2'd2); // [R5]
        endcase
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_byte_taken(lvc_byte_st_t s);
        strip_valid && strip_ready && st_r == s;
    endsequence

    a_enable_reset: assert property ($rose(rst_b) |-> ctrl_r[0] && !ctrl_r[1] && ctrl_r[9:2] == 8'h00) // [R1]
        else $error("control reset value wrong");
    a_ctrl_readback: assert property (reg_rd && reg_idx == `LVC_IDX_CTRL |=> reg_rdata[0] == $past(vid_locked)) // [R1]
        else $error("control bit 0 read does not show video detect");
    a_disabled_drop: assert property (!ctrl_r[0] |-> !u_fifo.push) // [R1]
        else $error("pixel queued while disabled");
    a_mirror_pos: assert property (u_fifo.push && ctrl_r[1] |-> fifo_in[35:24] == 12'(width_m1_r - (vid_x - crop_x_r) + ctrl_r[3:2])) // [R3]
        else $error("mirrored position wrong");
    a_pad_pos: assert property (u_fifo.push && !ctrl_r[1] |-> fifo_in[35:24] == 12'(vid_x - crop_x_r + ctrl_r[3:2])) // [R4]
        else $error("padded position wrong");
    a_crop_x_window: assert property (vid_valid && (vid_x < crop_x_r || vid_x > 12'(crop_x_r) + width_m1_r) |-> !u_fifo.push) // [R8] [R10]
        else $error("pixel outside x window queued");
    a_crop_y_window: assert property (vid_valid && (vid_y < crop_y_r || vid_y > 12'(crop_y_r) + height_m1_r) |-> !u_fifo.push) // [R9] [R11]
        else $error("pixel outside y window queued");
    a_win_forward: assert property (vid_valid && vid_ready && ctrl_r[0] && in_win |-> u_fifo.push) // [R12]
        else $error("window pixel not queued");
    a_byte_order: assert property (s_byte_taken(LVC_ST_HI) ##1 (strip_valid && strip_ready) |-> st_r == LVC_ST_MID) // [R12]
        else $error("middle byte did not follow high byte");
    a_low_pops: assert property (s_byte_taken(LVC_ST_LO) |-> fifo_pop ##1 st_r == LVC_ST_HI) // [R12]
        else $error("word not retired after low byte");
    a_low_select: assert property (st_r == LVC_ST_LO && ctrl_r[5:4] == 2'b10 |-> strip_byte == head_rgb[23:16]) // [R5]
        else $error("low byte select 10 not red");
    a_mid_select: assert property (st_r == LVC_ST_MID && ctrl_r[7:6] == 2'b01 |-> strip_byte == head_rgb[23:16]) // [R6]
        else $error("middle byte select 01 not red");
    a_high_select: assert property (st_r == LVC_ST_HI && ctrl_r[9:8] == 2'b10 |-> strip_byte == head_rgb[7:0]) // [R7]
        else $error("high byte select 10 not blue");
endmodule // lvc_crop_color
`default_nettype wire

// >>> verification/lvc_crop_color_test.sv
// self-checking testbench for the video crop and colour block
`timescale 1ns/1ps
`default_nettype none
`include "lvc_cfg.svh"

module lvc_crop_color_test;
    logic        clk_sys;      // 40 mhz system clock
    logic        rst_b;        // synchronous reset, active low
    logic        reg_wr;       // register write strobe
    logic        reg_rd;       // register read strobe
    logic [2:0]  reg_idx;      // register index
    logic [15:0] reg_wdata;    // write data
    logic [15:0] reg_rdata;    // read data
    logic        vid_locked;   // valid video detected
    logic        vid_valid;    // input pixel present
    logic        vid_ready;    // block takes a pixel
    logic [10:0] vid_x;        // pixel column
    logic [10:0] vid_y;        // pixel row
    logic [23:0] vid_rgb;      // pixel colour
    logic        strip_valid;  // output byte present
    logic        strip_ready;  // bench takes the byte
    logic [7:0]  strip_byte;   // output byte
    logic [1:0]  strip_phase;  // byte phase
    logic [11:0] strip_pos;    // strip pixel index
    logic [9:0]  strip_line;   // line within window
    logic        ctrl_enable;  // stored enable
    int          errors;       // mismatches seen
    int          checked;      // comparisons made

    always #12.5 clk_sys = ~clk_sys;

    lvc_crop_color dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vid_locked(vid_locked), .vid_valid(vid_valid),
        .vid_ready(vid_ready), .vid_x(vid_x), .vid_y(vid_y), .vid_rgb(vid_rgb), .strip_valid(strip_valid),
        .strip_ready(strip_ready), .strip_byte(strip_byte), .strip_phase(strip_phase),
        .strip_pos(strip_pos), .strip_line(strip_line), .ctrl_enable(ctrl_enable)
    );

    // verdict and end of run; the only place the run stops
    task test_done;
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // compare any design value, widened to 16 bits
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a bounded wait ran out: count it and stop
    task timeout;
        chk(16'h0000, 16'h0001);
        test_done;
    endtask

    // one register write, strobe held for exactly one edge
    task reg_write(input logic [2:0] i, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_idx   <= i;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // one register read; data is judged in the cycle after the taking edge
    task reg_chk(input logic [2:0] i, input logic [15:0] e);
        @(posedge clk_sys);
        reg_rd  <= 1'b1;
        reg_idx <= i;
        @(posedge clk_sys);
        reg_rd  <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask

    // offer one pixel; ok tells whether the handshake completed within the bound
    task send_pix(input logic [10:0] x, input logic [10:0] y, output bit ok);
        int n;
        @(posedge clk_sys);
        vid_valid <= 1'b1;
        vid_x     <= x;
        vid_y     <= y;
        vid_rgb   <= {x[7:0], y[7:0], 8'h5a};
        ok = 1'b0;
        for (n = 0; n < 40 && !ok; n++) begin
            @(negedge clk_sys);
            ok = (vid_ready === 1'b1);
            @(posedge clk_sys);
        end
        vid_valid <= 1'b0;
    endtask

    // colour of one output slot (0 high, 1 middle, 2 low) for a selector code
    function automatic logic [7:0] col(input logic [1:0] s, input int slot, input logic [23:0] p);
        int c;  // 0 red, 1 green, 2 blue
        if (slot == 0) c = (s == 2'd3) ? 0 : int'(s);
        else if (slot == 1) c = (s == 2'd0 || s == 2'd3) ? 1 : (s == 2'd1) ? 0 : 2;
        else c = (s == 2'd1) ? 1 : (s == 2'd2) ? 0 : 2;
        return p[23-8*c -: 8];
    endfunction

    // take the three bytes of one pixel, stalling a cycle before each take
    task get_pix(input logic [11:0] pos, input logic [9:0] line, input logic [9:0] ctl, input logic [23:0] p);
        int k;
        int n;
        for (k = 0; k < 3; k++) begin
            n = 0;
            @(negedge clk_sys);
            while (strip_valid !== 1'b1 && n < 40) begin
                @(negedge clk_sys);
                n++;
            end
            if (n >= 40) timeout;
            chk(strip_phase, 16'(k));
            chk(strip_byte, col(ctl[9-2*k -: 2], k, p));
            chk(strip_pos, pos);
            chk(strip_line, line);
            @(posedge clk_sys);
            strip_ready <= 1'b1;
            @(posedge clk_sys);
            strip_ready <= 1'b0;
        end
    endtask

    // nothing may be waiting on the strip side
    task chk_idle;
        repeat (4) @(negedge clk_sys);
        chk(strip_valid, 16'h0000);
    endtask

    // reset values and the locked readback of the enable bit
    task t_reset;
        chk(ctrl_enable, 16'h0001);
        reg_chk(3'h0, 16'h0001);
        @(posedge clk_sys);
        vid_locked <= 1'b0;
        reg_chk(3'h0, 16'h0000);
        @(posedge clk_sys);
        vid_locked <= 1'b1;
        reg_chk(3'h1, 16'h0000);
        reg_chk(3'h2, 16'h0000);
        reg_chk(3'h3, 16'h00ff);
        reg_chk(3'h4, 16'h001f);
    endtask

    // all-ones writes show field widths; unmapped places read zero
    task t_regs;
        logic [15:0] e [8];
        int i;
        e = '{16'h03ff, 16'h07ff, 16'h07ff, 16'h03ff, 16'h03ff, 16'h0000, 16'h0000, 16'h0000};
        for (i = 0; i < 8; i++) begin
            reg_write(3'(i), 16'hffff);
            reg_chk(3'(i), e[i]);
        end
        reg_write(3'h0, 16'h03fe);
        reg_chk(3'h0, 16'h03ff);
        chk(ctrl_enable, 16'h0000);
    endtask

    // one pixel at the origin through every selector code; origin chosen so red, green and blue differ
    task t_colors;
        logic [15:0] c [6];
        int i;
        bit ok;
        c = '{16'h0001, 16'h0151, 16'h02a1, 16'h03f1, 16'h0141, 16'h0091};
        reg_write(3'h1, 16'h0033);
        reg_write(3'h2, 16'h0077);
        reg_write(3'h3, 16'h00ff);
        reg_write(3'h4, 16'h001f);
        for (i = 0; i < 6; i++) begin
            reg_write(3'h0, c[i]);
            send_pix(11'h033, 11'h077, ok);
            chk(16'(ok), 16'h0001);
            get_pix(12'd0, 10'd0, c[i][9:0], 24'h33_775a);
        end
    endtask

    // small window with mirror and skip of three; pixels around it are dropped
    task t_window;
        int x;
        int y;
        bit ok;
        reg_write(3'h1, 16'h0005);
        reg_write(3'h2, 16'h0003);
        reg_write(3'h3, 16'h0003);
        reg_write(3'h4, 16'h0001);
        reg_write(3'h0, 16'h000f);
        for (y = 2; y < 6; y++)
            for (x = 4; x < 10; x++)
                send_pix(11'(x), 11'(y), ok);
        for (y = 3; y < 5; y++)
            for (x = 5; x < 9; x++)
                get_pix(12'(3 + 3 - (x - 5)), 10'(y - 3), 10'h00f, {8'(x), 8'(y), 8'h5a});
        chk_idle;
    endtask

    // a disabled controller drops pixels inside the window
    task t_off;
        bit ok;
        reg_write(3'h0, 16'h0000);
        @(negedge clk_sys);
        chk(ctrl_enable, 16'h0000);
        send_pix(11'd5, 11'd3, ok);
        chk(16'(ok), 16'h0001);
        chk_idle;
    endtask

    // fill the buffer with the strip stalled until it refuses, then drain it
    task t_fifo;
        int i;
        bit ok;
        reg_write(3'h1, 16'h0000);
        reg_write(3'h2, 16'h0000);
        reg_write(3'h3, 16'h00ff);
        reg_write(3'h0, 16'h0001);
        for (i = 0; i < 17; i++) begin
            send_pix(11'(i), 11'd0, ok);
            chk(16'(ok), 16'(i < 16));
        end
        for (i = 0; i < 16; i++)
            get_pix(12'(i), 10'd0, 10'h001, {8'(i), 8'h00, 8'h5a});
        chk_idle;
        chk(vid_ready, 16'h0001);
    endtask

    // main sequence
    initial begin
        clk_sys     = 1'b0;
        rst_b       = 1'b0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_idx     = 3'h0;
        reg_wdata   = 16'h0000;
        vid_locked  = 1'b1;
        vid_valid   = 1'b0;
        vid_x       = 11'h000;
        vid_y       = 11'h000;
        vid_rgb     = 24'h00_0000;
        strip_ready = 1'b0;
        errors      = 0;
        checked     = 0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_colors;
        t_window;
        t_off;
        t_fifo;
        test_done;
    end
endmodule // lvc_crop_color_test
`default_nettype wire
